// [hw/down_timer_pkg.sv]
// constants shared by the down timer, pwm and buzzer logic
// assumes a single core clock; registers are plain ports, no bus
package down_timer_pkg;
	localparam int          CNT_W            = 8;
	localparam logic [7:0]  COUNT_FULL       = 8'hff;
	localparam logic [7:0]  COUNT_ZERO       = 8'h00;
	localparam logic [7:0]  RESET_COUNT      = 8'h00;
	// control one field positions
	localparam int          CTL1_RUN_BIT     = 0;
	localparam int          CTL1_RELOAD_BIT  = 1;
	localparam int          CTL1_ONESHOT_BIT = 2;
	localparam int          CTL1_PWM_AL_BIT  = 6;
	localparam int          CTL1_PWM_EN_BIT  = 7;
	// control two field positions
	localparam int          CTL2_PS_LSB      = 0;
	localparam int          CTL2_PS_MSB      = 2;
	localparam int          CTL2_PS_EN_N_BIT = 3;
	localparam int          CTL2_EDGE_BIT    = 4;
	localparam int          CTL2_CSEL_BIT    = 5;
	// buzzer control field positions
	localparam int          BZ_SEL_LSB       = 0;
	localparam int          BZ_SEL_MSB       = 3;
	localparam int          BZ_SRC_BIT       = 3;
	localparam int          BZ_EN_BIT        = 7;
	// interrupt flag position
	localparam int          UNDERFLOW_BIT    = 3;
	localparam logic [7:0]  RESET_CTL        = 8'h00;
	localparam logic [7:0]  RESET_CTL2       = 8'h08;
	localparam logic [1:0]  SYNC_RESET       = 2'h0;
endpackage

// [hw/tick_if.sv]
// bundle joining the timer core to its buzzer divider
// assumes both ends share core_clk_i
`timescale 1ns/1ps
interface tick_if;
	logic       pre_tick;
	logic       tmr_tick;
	logic       enable;
	logic [3:0] select;
	logic       wave;
	modport core (output pre_tick, tmr_tick, enable, select, input wave);
	modport buzz (input pre_tick, tmr_tick, enable, select, output wave);
endinterface

// [hw/buzzer_divider.sv]
// buzzer divider: toggles output every 2^sel[2:0] source ticks
// assumes ticks are one-cycle pulses on core_clk_i
`timescale 1ns/1ps
module buzzer_divider
	import down_timer_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	tick_if.buzz      bz
);
	typedef struct packed {
		logic [7:0] div;
		logic       wave;
	} bz_state_t;

	bz_state_t st_reg;
	bz_state_t st_next;
	logic      src_tick;

	// source pick; toggle at 2^n ticks gives 1:2 to 1:256 overall
	always_comb begin
		st_next  = st_reg;
		src_tick = bz.select[BZ_SRC_BIT] ? bz.tmr_tick : bz.pre_tick;
		if (!bz.enable) begin
			st_next = '0;
		end else if (src_tick) begin
			if (st_reg.div >= ((8'h01 << bz.select[BZ_SRC_BIT-1:BZ_SEL_LSB])
			                   - 8'h01)) begin
				st_next.div  = 8'h00;
				st_next.wave = ~st_reg.wave;
			end else begin
				st_next.div = st_reg.div + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bz.wave = st_reg.wave;
endmodule

// [hw/down_timer_pwm_buzzer.sv]
// eight-bit down timer with prescaler, pwm and buzzer on one pin
// assumes firmware strobes writes as one-cycle pulses on core_clk_i
`timescale 1ns/1ps
module down_timer_pwm_buzzer
	import down_timer_pkg::*;
#(
	parameter int PS_W = 8
) (
	input  wire logic         core_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [7:0]   timer_control_one_i,
	input  wire logic [7:0]   timer_control_two_i,
	input  wire logic [7:0]   buzzer_control_i,
	input  wire logic [7:0]   timer_count_wdata_i,
	input  wire logic         timer_count_we_i,
	input  wire logic [7:0]   pwm_duty_value_i,
	input  wire logic         underflow_flag_clear_i,
	input  wire logic         underflow_irq_enable_i,
	input  wire logic         global_irq_enable_i,
	input  wire logic         pin_option_pwm_i,
	input  wire logic         pin_option_buzzer_i,
	input  wire logic         inst_tick_i,
	input  wire logic         shared_timer_pin_i,
	input  wire logic         pin_gpio_out_i,
	input  wire logic         pin_gpio_oe_i,
	output logic [7:0]        timer_count_register_o,
	output logic [7:0]        timer_reload_value_o,
	output logic [PS_W-1:0]   prescaler_live_value_o,
	output logic [7:0]        interrupt_flag_register_o,
	output logic              irq_o,
	output logic              wake_o,
	output logic              pwm_output_o,
	output logic              buzzer_output_o,
	output logic              shared_timer_pin_o,
	output logic              shared_timer_pin_oe_o
);
	typedef struct packed {
		logic [1:0]      sync;
		logic            pin_last;
		logic [PS_W-1:0] pre;
		logic [7:0]      count;
		logic [7:0]      reload;
		logic            stopped;
		logic            flag;
		logic            pwm;
		logic            pre_tick;
		logic            tmr_tick;
	} tmr_state_t;

	tmr_state_t st_reg;
	tmr_state_t st_next;
	tick_if     tk ();

	logic run;
	logic csel;
	logic edge_fall;
	logic ps_bypass;
	logic [2:0] ps_sel;
	logic src_tick;
	logic pin_rise;
	logic pin_fall;
	logic pre_out;
	logic pwm_on;
	logic bz_on;
	logic uf_set;
	logic [7:0] flag_word;

	// division at a given select: 2^(sel+1) source ticks per output
	function automatic logic pre_done(input logic [PS_W-1:0] v,
	                                  input logic [2:0] sel);
		logic [PS_W-1:0] lim;
		lim = PS_W'((9'h002 << sel) - 9'h001);
		return v >= lim;
	endfunction

	// field decode of the control inputs
	assign run       = timer_control_one_i[CTL1_RUN_BIT];
	assign csel      = timer_control_two_i[CTL2_CSEL_BIT];
	assign edge_fall = timer_control_two_i[CTL2_EDGE_BIT];
	assign ps_bypass = timer_control_two_i[CTL2_PS_EN_N_BIT];
	assign ps_sel    = timer_control_two_i[CTL2_PS_MSB:CTL2_PS_LSB];

	// edge detect after the second sync stage only
	// resets low: an idle-high pin shows one rise after reset, harmless
	// since the select bit comes out of reset on the instruction clock
	assign pin_rise = st_reg.sync[1] & ~st_reg.pin_last;
	assign pin_fall = ~st_reg.sync[1] & st_reg.pin_last;
	always_comb begin
		src_tick = inst_tick_i;
		if (csel) begin
			src_tick = edge_fall ? pin_fall : pin_rise;
		end
	end

	// prescaler output, or the raw source when bypassed
	assign pre_out = ps_bypass ? src_tick :
	                 (src_tick && pre_done(st_reg.pre, ps_sel));

	always_comb begin
		st_next          = st_reg;
		st_next.sync     = {st_reg.sync[0], shared_timer_pin_i};
		st_next.pin_last = st_reg.sync[1];
		st_next.pre_tick = 1'b0;
		st_next.tmr_tick = 1'b0;
		uf_set           = 1'b0;
		// prescaler runs only when inserted; cleared on bypass
		if (ps_bypass || !run) begin
			st_next.pre = '0;
		end else if (src_tick) begin
			st_next.pre = pre_done(st_reg.pre, ps_sel) ? '0
			            : st_reg.pre + 1'b1;
		end
		// counter; no mode gating by standby, so it keeps counting
		// a write beats a tick that lands in the same cycle
		if (timer_count_we_i) begin
			st_next.count   = timer_count_wdata_i;
			st_next.reload  = timer_count_wdata_i;
			st_next.stopped = 1'b0;
		end else if (run && pre_out && !st_reg.stopped) begin
			st_next.pre_tick = 1'b1;
			if (st_reg.count == COUNT_ZERO) begin
				st_next.flag     = 1'b1;
				uf_set           = 1'b1;
				st_next.tmr_tick = 1'b1;
				if (timer_control_one_i[CTL1_ONESHOT_BIT]) begin
					st_next.stopped = 1'b1;
				end else if (timer_control_one_i[CTL1_RELOAD_BIT]) begin
					st_next.count = st_reg.reload;
				end else begin
					st_next.count = COUNT_FULL;
				end
			end else begin
				st_next.count = st_reg.count - 8'h01;
			end
		end else if (run && pre_out) begin
			st_next.pre_tick = 1'b1;
		end
		// set wins over a clear in the same cycle
		if (underflow_flag_clear_i && !uf_set) begin
			st_next.flag = 1'b0;
		end
		// compare of live count against duty
		st_next.pwm = (st_next.count < pwm_duty_value_i);
	end

	// reset loads constants only
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg        <= '0;
			st_reg.sync   <= SYNC_RESET;
			st_reg.count  <= RESET_COUNT;
			st_reg.reload <= RESET_COUNT;
		end else begin
			st_reg <= st_next;
		end
	end

	// buzzer divider hookup
	assign tk.pre_tick = st_reg.pre_tick;
	assign tk.tmr_tick = st_reg.tmr_tick;
	assign tk.enable   = buzzer_control_i[BZ_EN_BIT];
	assign tk.select   = buzzer_control_i[BZ_SEL_MSB:BZ_SEL_LSB];

	buzzer_divider u_buzz (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.bz         (tk.buzz)
	);

	// pin mux: pwm first, then buzzer, else general purpose
	assign pwm_on = timer_control_one_i[CTL1_PWM_EN_BIT] & pin_option_pwm_i;
	assign bz_on  = buzzer_control_i[BZ_EN_BIT] & pin_option_buzzer_i;
	// polarity flips the registered level; reset shows the inactive level
	assign pwm_output_o = st_reg.pwm ^ timer_control_one_i[CTL1_PWM_AL_BIT];
	assign buzzer_output_o = tk.wave;
	always_comb begin
		shared_timer_pin_o    = pin_gpio_out_i;
		shared_timer_pin_oe_o = pin_gpio_oe_i & ~csel;
		if (pwm_on) begin
			shared_timer_pin_o    = pwm_output_o;
			shared_timer_pin_oe_o = 1'b1;
		end else if (bz_on) begin
			shared_timer_pin_o    = tk.wave;
			shared_timer_pin_oe_o = 1'b1;
		end
	end

	// status out; live values, not stored copies
	assign timer_count_register_o = st_reg.count;
	assign timer_reload_value_o   = st_reg.reload;
	assign prescaler_live_value_o = st_reg.pre;
	// flag word: only the underflow position is kept in this block
	always_comb begin
		flag_word                = '0;
		flag_word[UNDERFLOW_BIT] = st_reg.flag;
	end
	assign interrupt_flag_register_o = flag_word;
	assign irq_o  = st_reg.flag & underflow_irq_enable_i
	              & global_irq_enable_i;
	assign wake_o = st_reg.flag & underflow_irq_enable_i;
endmodule

// [bench/down_timer_props.sv]
// assertions on the down timer top-level ports
// bound into every down_timer_pwm_buzzer instance
`timescale 1ns/1ps
module down_timer_props (
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] timer_control_one_i,
	input wire logic [7:0] timer_count_wdata_i,
	input wire logic       timer_count_we_i,
	input wire logic [7:0] pwm_duty_value_i,
	input wire logic       underflow_flag_clear_i,
	input wire logic       underflow_irq_enable_i,
	input wire logic       global_irq_enable_i,
	input wire logic       pin_option_pwm_i,
	input wire logic [7:0] timer_count_register_o,
	input wire logic [7:0] timer_reload_value_o,
	input wire logic [7:0] interrupt_flag_register_o,
	input wire logic       irq_o,
	input wire logic       pwm_output_o,
	input wire logic       shared_timer_pin_o,
	input wire logic       shared_timer_pin_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// short aliases keep the properties readable
	wire logic [7:0] cnt = timer_count_register_o;
	wire logic [7:0] ctl = timer_control_one_i;
	wire logic       we  = timer_count_we_i;
	wire logic       flg = interrupt_flag_register_o[3];
	// continuous mode leaving zero with no write in the way
	sequence wrap_s;
		(!ctl[2] && cnt == 8'h00 && !we) ##1 (cnt != 8'h00);
	endsequence
	a_write_loads_both: assert property (we |=>
		cnt == $past(timer_count_wdata_i) &&
		timer_reload_value_o == $past(timer_count_wdata_i))
		else $error("write did not load count and reload");
	a_count_steps_down: assert property ($past(cnt) != 8'h00 &&
		!$past(we) && cnt != $past(cnt) |-> cnt == $past(cnt) - 8'h01)
		else $error("count moved by other than one");
	a_halt_holds: assert property (!ctl[0] && !we |=> $stable(cnt))
		else $error("count moved while halted");
	a_oneshot_stops: assert property (ctl[2] && cnt == 8'h00 && !we
		|=> cnt == 8'h00)
		else $error("one-shot restarted after underflow");
	a_wrap_value: assert property (wrap_s |-> cnt ==
		($past(ctl[1]) ? timer_reload_value_o : 8'hff))
		else $error("wrong restart value");
	a_wrap_flag: assert property (wrap_s |-> flg)
		else $error("underflow did not set flag");
	a_flag_sticky: assert property (flg && !underflow_flag_clear_i |=> flg)
		else $error("flag dropped without clear");
	a_irq_gate: assert property (irq_o == (flg && underflow_irq_enable_i &&
		global_irq_enable_i))
		else $error("irq not gated by flag and enables");
	a_pwm_level: assert property ($changed(cnt) &&
		$stable(pwm_duty_value_i) |-> (pwm_output_o ^ ctl[6]) ==
		(cnt < pwm_duty_value_i))
		else $error("pwm level wrong for count");
	a_pin_pwm: assert property (ctl[7] && pin_option_pwm_i |->
		shared_timer_pin_oe_o && shared_timer_pin_o == pwm_output_o)
		else $error("pin not carrying pwm");
endmodule
bind down_timer_pwm_buzzer down_timer_props chk (.core_clk_i, .sys_rst_i,
	.timer_control_one_i, .timer_count_wdata_i, .timer_count_we_i,
	.pwm_duty_value_i, .underflow_flag_clear_i, .underflow_irq_enable_i,
	.global_irq_enable_i, .pin_option_pwm_i, .timer_count_register_o,
	.timer_reload_value_o, .interrupt_flag_register_o, .irq_o, .pwm_output_o,
	.shared_timer_pin_o, .shared_timer_pin_oe_o);

// [bench/ext_clock_source.sv]
// external clock source standing on the shared timer pin
// assumes the bench resolves the pin with a pull-up when released
`timescale 1ns/1ps
module ext_clock_source (
	input  wire logic core_clk_i,
	output logic      drive_o,
	output logic      level_o
);
	// idle high so taking the pin makes no edge
	initial begin
		drive_o = 1'b0;
		level_o = 1'b1;
	end
	// n toggles, four clocks apart, slow enough for the synchroniser
	task automatic burst(input int n);
		drive_o = 1'b1;
		repeat (n) begin
			repeat (4) @(posedge core_clk_i);
			#1 level_o = ~level_o;
		end
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	// let go of the pin; the pull-up takes it high
	task automatic drop();
		drive_o = 1'b0;
		level_o = 1'b1;
	endtask
endmodule

// [bench/down_timer_pwm_buzzer_test.sv]
// self-checking bench for the down timer, pwm and pin mux
// assumes the checker is bound in and the pin has a pull-up
`timescale 1ns/1ps
module down_timer_pwm_buzzer_test;
	import down_timer_pkg::*;
	logic        core_clk_i, sys_rst_i, we, clr, ie, global_irq_enable, opt_pwm, tick;
	logic [7:0]  ctl1, ctl2, bzc, wdata, duty, cnt, rld, psv, flags, v;
	logic        irq, wake, pwm, bz, pin_o, pin_oe, pin, src_drv, src_lvl;
	logic        opt_bz, gpio_oe, w;
	int          t_a, t_b;
	logic [31:0] seed = 32'h0460d85c;
	int          err_total = 0;
	int          compares = 0;
	// released pin floats to the pull-up level
	assign pin = pin_oe ? pin_o : (src_drv ? src_lvl : 1'b1);
	down_timer_pwm_buzzer uut (.core_clk_i, .sys_rst_i,
		.timer_control_one_i(ctl1), .timer_control_two_i(ctl2),
		.buzzer_control_i(bzc), .timer_count_wdata_i(wdata),
		.timer_count_we_i(we), .pwm_duty_value_i(duty),
		.underflow_flag_clear_i(clr), .underflow_irq_enable_i(ie),
		.global_irq_enable_i(global_irq_enable), .pin_option_pwm_i(opt_pwm),
		.pin_option_buzzer_i(opt_bz), .inst_tick_i(tick),
		.shared_timer_pin_i(pin), .pin_gpio_out_i(1'b0),
		.pin_gpio_oe_i(gpio_oe),
		.timer_count_register_o(cnt), .timer_reload_value_o(rld),
		.prescaler_live_value_o(psv), .interrupt_flag_register_o(flags),
		.irq_o(irq), .wake_o(wake), .pwm_output_o(pwm), .buzzer_output_o(bz),
		.shared_timer_pin_o(pin_o), .shared_timer_pin_oe_o(pin_oe));
	ext_clock_source src (.core_clk_i, .drive_o(src_drv), .level_o(src_lvl));
	// 100 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] restart(input logic rl, input logic [7:0] r);
		return rl ? r : 8'hff;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic load(input logic [7:0] d);
		wdata = d;
		we = 1'b1;
		step(1);
		we = 1'b0;
	endtask
	task automatic test_done();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// cut a hang short well past the expected run length
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	// main sequence
	initial begin
		{we, clr, ie, global_irq_enable, opt_pwm, tick, opt_bz, gpio_oe} = '0;
		{ctl1, bzc, wdata, duty} = '0;
		ctl2 = RESET_CTL2;
		sys_rst_i = 1'b1;
		step(6);
		sys_rst_i = 1'b0;
		check(cnt, 8'h00);
		check(flags, 8'h00);
		tick = 1'b1;
		// random short continuous frames, clear folded into the write
		repeat (8) begin
			seed = xs(seed);
			v = {4'h0, seed[3:0]} + 8'h02;
			ctl1 = {seed[7:6], 4'h0, seed[8], 1'b1};
			{ie, global_irq_enable, opt_pwm} = seed[11:9];
			duty = seed[12] ? 8'h00 : v >> seed[14:13];
			bzc = seed[23:16];
			clr = 1'b1;
			load(v);
			clr = 1'b0;
			step(v);
			check(flags[3], 1'b0);
			check(pwm, ctl1[6] ^ (duty != 8'h00));
			step(1);
			check(flags, 8'h08);
			check(cnt, restart(ctl1[1], v));
			check(irq, ie & global_irq_enable);
			check(wake, ie);
			check(pin_oe, ctl1[7] & opt_pwm);
			check(pwm, ctl1[6] ^ (cnt < duty));
		end
		v = cnt;
		ctl1 = 8'h00;
		step(5);
		check(cnt, v);
		// one-shot stops at zero and ignores further ticks
		ctl1 = 8'h05;
		clr = 1'b1;
		load(8'h03);
		clr = 1'b0;
		step(20);
		check(cnt, 8'h00);
		check(flags, 8'h08);
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(3);
		check(flags[3], 1'b0);
		// pin clock: 5 falls and 4 rises before release
		for (int e = 0; e < 2; e++) begin
			ctl1 = 8'h01;
			ctl2 = {2'b00, 1'b1, e[0], 1'b1, 3'h0};
			gpio_oe = 1'b1;
			load(8'h40);
			src.burst(9);
			check(cnt, 8'h40 - (e[0] ? 8'h05 : 8'h04));
			check(pin_oe, 1'b0);
			src.drop();
		end
		gpio_oe = 1'b0;
		// every prescaler ratio, sampled mid third period
		for (int s = 0; s < 8; s++) begin
			ctl1 = 8'h00;
			ctl2 = {5'h00, s[2:0]};
			load(8'hf0);
			ctl1 = 8'h01;
			step(5 << s);
			check(cnt, 8'hee);
			check(psv, 8'h01 << s);
		end
		// buzzer on the pin: timer input clock, then underflow source
		opt_bz = 1'b1;
		for (int b = 0; b < 2; b++) begin
			ctl1 = 8'h03;
			ctl2 = RESET_CTL2;
			bzc = 8'h00;
			load(8'h03);
			bzc = {4'h8, b[0], 3'h1};
			t_a = 0;
			t_b = 0;
			for (int c = 1; c <= 40; c++) begin
				w = bz;
				step(1);
				if (bz !== w && t_a == 0) begin
					t_a = c;
				end else if (bz !== w && t_b == 0) begin
					t_b = c;
				end
			end
			check(8'(t_b - t_a), b[0] ? 8'h08 : 8'h02);
			check(pin_oe, 1'b1);
			check(pin_o, bz);
		end
		test_done();
	end
endmodule
